// ===== design/fss_top.sv
`timescale 1ns/1ps
module fss_top (
   input  wire logic        clk,            // 10 MHz system clock
   input  wire logic        rst_n,          // async reset, active low
   // pins from outside the clock domain
   input  wire logic        chan_enable_pin, // channel enable pin
   input  wire logic        bias_sense_pin,  // bias present level
   // command port from the bus interface
   input  wire logic        cmd_req,        // command strobe, one cycle
   input  wire logic [7:0]  cmd_code,       // command code
   input  wire logic        busy_now,       // device still busy
   // read port from the bus interface
   input  wire logic        rd_req,         // read strobe, one cycle
   input  wire logic [7:0]  rd_code,        // register code to read
   output logic      [15:0] rd_data,        // read data
   output logic             rd_valid,       // read data valid pulse
   // fault and warning events from the monitors
   input  wire logic        fault_shutdown, // fault turned channel off
   input  wire logic        out_over_fault, // output overvoltage fault
   input  wire logic        out_over_warn,  // output overvoltage warning
   input  wire logic        out_under_warn, // output undervoltage warning
   input  wire logic        out_under_fault,// output undervoltage fault
   input  wire logic        vout_max_req,   // set above maximum limit
   input  wire logic        ton_max_fault,  // turn-on timeout fault
   input  wire logic        other_fault,    // fault not in bits 7..1
   // detail summaries kept elsewhere
   input  wire logic        input_detail_any, // input detail nonzero
   input  wire logic        in_under_fault,   // input undervoltage fault
   input  wire logic        temp_detail_any,  // temperature detail set
   input  wire logic        cml_detail_any,   // cml detail nonzero
   input  wire logic        mfr_detail_any,   // mfr details nonzero
   // power state
   input  wire logic        power_good_out, // power good pin level
   input  wire logic        pg_enable,      // power good pin enabled
   input  wire logic        chan_output_on, // channel delivering power
   // outputs
   output logic             alert_out_n,    // alert pin output value
   output logic             alert_oe,       // alert pin drive enable
   output logic             chan_latched,   // channel latched off
   output logic             clear_pulse,    // clear for other details
   output logic             chan_run_allow  // channel may run
);
   fss_det_if det_bus ();

   logic [1:0]  pins_sync;
   logic        en_sync;
   logic        bias_sync;
   logic        en_prev;
   logic        bias_prev;
   logic        en_toggle;
   logic        bias_return;
   logic        is_clear;
   logic        is_onoff;
   logic        latched_off;
   logic        next_latched_off;
   logic        busy_bit;
   logic        other_bit;
   logic        alert;
   logic        in_prev;
   logic        temp_prev;
   logic        cml_prev;
   logic        mfr_prev;
   logic        ext_rise;
   logic        any_event;
   logic [15:0] sum_word;

   // command decode used by several processes
   function automatic logic cmd_is(input logic       req,
                                   input logic [7:0] code,
                                   input logic [7:0] want);
      cmd_is = req && (code == want);
   endfunction

   // both pins pass two flip-flops before any logic sees them
   fss_sync #(.W(fss_pkg::SYNC_WIDTH)) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({bias_sense_pin, chan_enable_pin}),
      .sync_out (pins_sync)
   );

   assign en_sync   = pins_sync[0];
   assign bias_sync = pins_sync[1];

   // edge history of the synchronised pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_prev   <= 1'b0;
         bias_prev <= 1'b0;
      end else begin
         en_prev   <= en_sync;
         bias_prev <= bias_sync;
      end
   end

   // release events for the latched off state
   assign en_toggle   = en_sync ^ en_prev;
   assign bias_return = bias_sync & ~bias_prev;

   // command decode
   assign is_clear = cmd_is(cmd_req, cmd_code, fss_pkg::CMD_CLEAR_FAULTS);
   assign is_onoff = cmd_is(cmd_req, cmd_code, fss_pkg::CMD_OPERATION) |
                     cmd_is(cmd_req, cmd_code, fss_pkg::CMD_ON_OFF_CFG);

   // latched off: a new shutdown wins over a release in the same cycle;
   // the clear command does not take part here
   always_comb begin
      next_latched_off = latched_off;
      if (en_toggle || is_onoff || bias_return) begin
         next_latched_off = 1'b0;
      end
      if (fault_shutdown) begin
         next_latched_off = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_off <= 1'b0;
      end else begin
         latched_off <= next_latched_off;
      end
   end

   // registered channel state outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_latched   <= 1'b0;
         chan_run_allow <= 1'b0;
      end else begin
         chan_latched   <= next_latched_off;
         chan_run_allow <= ~next_latched_off;
      end
   end

   // output-voltage detail byte lives in its own module
   assign det_bus.ov_fault  = out_over_fault;
   assign det_bus.ov_warn   = out_over_warn;
   assign det_bus.uv_warn   = out_under_warn;
   assign det_bus.uv_fault  = out_under_fault;
   assign det_bus.max_warn  = vout_max_req;
   assign det_bus.ton_fault = ton_max_fault;
   assign det_bus.clr       = is_clear;

   fss_vout_det u_vout (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (det_bus)
   );

   // sticky busy flag: a command seen while busy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_bit <= 1'b0;
      end else begin
         busy_bit <= (cmd_req & busy_now) | (busy_bit & ~is_clear);
      end
   end

   // sticky flag for faults with no summary bit of their own
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         other_bit <= 1'b0;
      end else begin
         other_bit <= other_fault | (other_bit & ~is_clear);
      end
   end

   // rising edges of detail summaries held elsewhere
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_prev   <= 1'b0;
         temp_prev <= 1'b0;
         cml_prev  <= 1'b0;
         mfr_prev  <= 1'b0;
      end else begin
         in_prev   <= input_detail_any;
         temp_prev <= temp_detail_any;
         cml_prev  <= cml_detail_any;
         mfr_prev  <= mfr_detail_any;
      end
   end

   assign ext_rise = (input_detail_any & ~in_prev)   |
                     (temp_detail_any  & ~temp_prev) |
                     (cml_detail_any   & ~cml_prev)  |
                     (mfr_detail_any   & ~mfr_prev);

   // every fault or warning event that should raise the alert
   assign any_event = out_over_fault | out_over_warn | out_under_warn |
                      out_under_fault | vout_max_req | ton_max_fault |
                      other_fault | (cmd_req & busy_now) | ext_rise |
                      fault_shutdown;

   // alert: set wins over the clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alert <= 1'b0;
      end else begin
         alert <= any_event | (alert & ~is_clear);
      end
   end

   // open-drain alert pin: drives low only while asserted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_out_n <= 1'b1;
         alert_oe    <= 1'b0;
      end else begin
         alert_out_n <= ~(any_event | (alert & ~is_clear));
         alert_oe    <= any_event | (alert & ~is_clear);
      end
   end

   // clear strobe passed on to the other detail registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clear_pulse <= 1'b0;
      end else begin
         clear_pulse <= is_clear;
      end
   end

   // summary word built continuously from the detail sources
   always_comb begin
      sum_word                       = 16'h0000;
      sum_word[fss_pkg::SW_VOUT]     = |det_bus.detail;
      sum_word[fss_pkg::SW_IOUT]     = 1'b0;
      sum_word[fss_pkg::SW_INPUT]    = input_detail_any;
      sum_word[fss_pkg::SW_MFR]      = mfr_detail_any;
      sum_word[fss_pkg::SW_PWR_NG]   = pg_enable & ~power_good_out;
      sum_word[fss_pkg::SW_BUSY]     = busy_bit;
      sum_word[fss_pkg::SW_OFF]      = ~chan_output_on | latched_off;
      sum_word[fss_pkg::SW_VOUT_OV]  =
         det_bus.detail[fss_pkg::VD_OV_FAULT];
      sum_word[fss_pkg::SW_IOUT_OC]  = 1'b0;
      sum_word[fss_pkg::SW_VIN_UV]   = in_under_fault;
      sum_word[fss_pkg::SW_TEMP]     = temp_detail_any;
      sum_word[fss_pkg::SW_CML]      = cml_detail_any;
      sum_word[fss_pkg::SW_HIGH_BYTE] =
         other_bit | (|det_bus.detail) | input_detail_any |
         mfr_detail_any | (pg_enable & ~power_good_out);
   end

   // read port: answer one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data  <= fss_pkg::RD_RESET;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_req;
         if (rd_req) begin
            case (rd_code)
               fss_pkg::CMD_SUM_LOW: begin
                  rd_data <= {8'h00, sum_word[7:0]};
               end
               fss_pkg::CMD_SUM_FULL: begin
                  rd_data <= sum_word;
               end
               fss_pkg::CMD_VOUT_DETAIL: begin
                  rd_data <= {8'h00, det_bus.detail};
               end
               default: begin
                  rd_data <= fss_pkg::RD_RESET;
               end
            endcase
         end
      end
   end
endmodule

// ===== design/fss_pkg.sv
package fss_pkg;
   // command codes seen on the command and read ports
   localparam logic [7:0] CMD_OPERATION    = 8'h01;
   localparam logic [7:0] CMD_ON_OFF_CFG   = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_SUM_LOW      = 8'h78;
   localparam logic [7:0] CMD_SUM_FULL     = 8'h79;
   localparam logic [7:0] CMD_VOUT_DETAIL  = 8'h7a;

   // summary word bit positions
   localparam int SW_VOUT      = 15;
   localparam int SW_IOUT      = 14;
   localparam int SW_INPUT     = 13;
   localparam int SW_MFR       = 12;
   localparam int SW_PWR_NG    = 11;
   localparam int SW_BUSY      = 7;
   localparam int SW_OFF       = 6;
   localparam int SW_VOUT_OV   = 5;
   localparam int SW_IOUT_OC   = 4;
   localparam int SW_VIN_UV    = 3;
   localparam int SW_TEMP      = 2;
   localparam int SW_CML       = 1;
   localparam int SW_HIGH_BYTE = 0;

   // output-voltage detail bit positions
   localparam int VD_OV_FAULT  = 7;
   localparam int VD_OV_WARN   = 6;
   localparam int VD_UV_WARN   = 5;
   localparam int VD_UV_FAULT  = 4;
   localparam int VD_MAX_WARN  = 3;
   localparam int VD_TON_FAULT = 2;

   // values after reset, and the synchroniser width
   localparam logic [7:0]  VD_RESET   = 8'h00;
   localparam logic [15:0] RD_RESET   = 16'h0000;
   localparam int          SYNC_WIDTH = 2;
endpackage

// ===== design/fss_det_if.sv
`timescale 1ns/1ps
interface fss_det_if;
   logic       ov_fault;   // overvoltage fault event
   logic       ov_warn;    // overvoltage warning event
   logic       uv_warn;    // undervoltage warning event
   logic       uv_fault;   // undervoltage fault event
   logic       max_warn;   // voltage above limit requested
   logic       ton_fault;  // turn-on timeout event
   logic       clr;        // clear all sticky bits
   logic [7:0] detail;     // sticky detail byte

   modport src (output ov_fault, ov_warn, uv_warn, uv_fault, max_warn,
                output ton_fault, clr, input detail);
   modport det (input ov_fault, ov_warn, uv_warn, uv_fault, max_warn,
                input ton_fault, clr, output detail);
endinterface

// ===== design/fss_sync.sv
`timescale 1ns/1ps
module fss_sync #(
   parameter int W = 2
) (
   input  wire logic         clk,      // system clock
   input  wire logic         rst_n,    // async reset, active low
   input  wire logic [W-1:0] async_in, // pins from outside the domain
   output logic      [W-1:0] sync_out  // synchronised levels
);
   // two flip-flops per bit; the first is read only by the second
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta        <= 1'b0;
            sync_out[i] <= 1'b0;
         end else begin
            meta        <= async_in[i];
            sync_out[i] <= meta;
         end
      end
   end
endmodule

// ===== design/fss_vout_det.sv
`timescale 1ns/1ps
module fss_vout_det (
   input  wire logic clk,   // system clock
   input  wire logic rst_n, // async reset, active low
   fss_det_if.det    d      // events in, sticky byte out
);
   logic [7:0] evt;

   // map events onto their detail positions; bits 1 and 0 never set
   always_comb begin
      evt                       = 8'h00;
      evt[fss_pkg::VD_OV_FAULT]  = d.ov_fault;
      evt[fss_pkg::VD_OV_WARN]   = d.ov_warn;
      evt[fss_pkg::VD_UV_WARN]   = d.uv_warn;
      evt[fss_pkg::VD_UV_FAULT]  = d.uv_fault;
      evt[fss_pkg::VD_MAX_WARN]  = d.max_warn;
      evt[fss_pkg::VD_TON_FAULT] = d.ton_fault;
   end

   // sticky bits: an event in the clear cycle still sets the bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d.detail <= fss_pkg::VD_RESET;
      end else begin
         d.detail <= evt | (d.detail & {8{~d.clr}});
      end
   end
endmodule

// ===== design/fss_top_end.sv
`timescale 1ns/1ps

// ===== dv/fss_monitor.sv
`timescale 1ns/1ps
// watches the top ports of the fault and status block
module fss_monitor (
   input wire logic        clk,             // system clock
   input wire logic        rst_n,           // async reset, active low
   input wire logic        chan_enable_pin, // enable pin
   input wire logic        bias_sense_pin,  // bias pin
   input wire logic        cmd_req,         // command strobe
   input wire logic [7:0]  cmd_code,        // command code
   input wire logic        rd_req,          // read strobe
   input wire logic [7:0]  rd_code,         // read code
   input wire logic [15:0] rd_data,         // read data
   input wire logic        rd_valid,        // read valid
   input wire logic        fault_shutdown,  // shutdown event
   input wire logic        out_over_fault,  // overvoltage event
   input wire logic        power_good_out,  // power good level
   input wire logic        pg_enable,       // power good enabled
   input wire logic        chan_output_on,  // output delivering
   input wire logic        alert_out_n,     // alert value
   input wire logic        alert_oe,        // alert drive
   input wire logic        chan_latched,    // latched off
   input wire logic        clear_pulse,     // clear pulse
   input wire logic        chan_run_allow   // run allowed
);
   logic [2:0] quiet;
   logic       en_q;
   logic       bias_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // counts edges since either pin last moved
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet  <= 3'h0;
         en_q   <= 1'h0;
         bias_q <= 1'h0;
      end else begin
         en_q   <= chan_enable_pin;
         bias_q <= bias_sense_pin;
         if (chan_enable_pin != en_q || bias_sense_pin != bias_q)
            quiet <= 3'h0;
         else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
      end
   end

   AST_RD_ANSWER: assert property (rd_valid == $past(rd_req))
      else $error("read valid not one cycle after strobe");
   AST_LOW_BYTE: assert property (rd_valid &&
      $past(rd_code) == fss_pkg::CMD_SUM_LOW |-> rd_data[15:8] == 8'h00)
      else $error("low summary read has upper byte set");
   AST_WORD_ZERO: assert property (rd_valid &&
      $past(rd_code) == fss_pkg::CMD_SUM_FULL |-> !rd_data[14] &&
      rd_data[10:8] == 3'h0 && !rd_data[4])
      else $error("unsupported summary bit set");
   AST_DETAIL_ZERO: assert property (rd_valid &&
      $past(rd_code) == fss_pkg::CMD_VOUT_DETAIL |-> rd_data[1:0] == 2'h0)
      else $error("unsupported detail bit set");
   AST_OFF_BIT: assert property (rd_valid &&
      $past(rd_code) == fss_pkg::CMD_SUM_FULL && !$past(chan_output_on)
      |-> rd_data[6])
      else $error("off bit clear while output not delivering");
   AST_PG_BIT: assert property (rd_valid &&
      $past(rd_code) == fss_pkg::CMD_SUM_FULL |->
      rd_data[11] == ($past(pg_enable) && !$past(power_good_out)))
      else $error("power not good bit wrong");
   AST_HIGH_BYTE: assert property (rd_valid &&
      $past(rd_code) == fss_pkg::CMD_SUM_FULL && rd_data[15:11] != 5'h00
      |-> rd_data[0])
      else $error("high byte flag clear with high bits set");
   AST_ALERT: assert property (
      out_over_fault |=> !alert_out_n && alert_oe)
      else $error("alert not raised by fault");
   AST_ALERT_OE: assert property (alert_oe != alert_out_n)
      else $error("alert enable disagrees with value");
   AST_CLEAR: assert property (cmd_req &&
      cmd_code == fss_pkg::CMD_CLEAR_FAULTS |=> clear_pulse)
      else $error("clear pulse missing");
   AST_CLEAR_CAUSE: assert property (clear_pulse |-> $past(cmd_req) &&
      $past(cmd_code) == fss_pkg::CMD_CLEAR_FAULTS)
      else $error("clear pulse without clear command");
   AST_SHUT: assert property (fault_shutdown |=>
      chan_latched && !chan_run_allow)
      else $error("shutdown did not latch channel off");
   AST_HOLD: assert property (chan_latched && quiet == 3'h7 &&
      !(cmd_req && (cmd_code == fss_pkg::CMD_OPERATION ||
      cmd_code == fss_pkg::CMD_ON_OFF_CFG)) |=> chan_latched)
      else $error("latched off state released on its own");
   AST_RELEASE: assert property (chan_latched && cmd_req &&
      cmd_code == fss_pkg::CMD_OPERATION && !fault_shutdown
      |=> !chan_latched)
      else $error("on command did not release latch");
endmodule

// ===== dv/fss_host_model.sv
`timescale 1ns/1ps
// host side: issues commands and reads, one strobe cycle each
module fss_host_model (
   input  wire logic        clk,      // system clock
   input  wire logic [15:0] rd_data,  // read data
   input  wire logic        rd_valid, // read valid
   output logic             cmd_req,  // command strobe
   output logic      [7:0]  cmd_code, // command code
   output logic             rd_req,   // read strobe
   output logic      [7:0]  rd_code   // read code
);
   // idle strobes
   initial begin
      cmd_req  = 1'h0;
      cmd_code = 8'h00;
      rd_req   = 1'h0;
      rd_code  = 8'h00;
   end

   // one-cycle command, stale code inverted afterwards
   task send_cmd(input logic [7:0] code);
      @(negedge clk);
      cmd_req  = 1'h1;
      cmd_code = code;
      @(negedge clk);
      cmd_req  = 1'h0;
      cmd_code = ~code;
   endtask

   // one-cycle read, answer taken one cycle later
   // the bench reads the detail register after each output-voltage event, then the summary
   task read_reg(input logic [7:0] code, output logic [15:0] d,
                 output logic v);
      @(negedge clk);
      rd_req  = 1'h1;
      rd_code = code;
      @(negedge clk);
      rd_req  = 1'h0;
      rd_code = ~code;
      d       = rd_data;
      v       = rd_valid;
   endtask
endmodule

// ===== dv/fss_top_tb.sv
`timescale 1ns/1ps
bind fss_top fss_monitor u_mon (.*);
// drives the status block through host reads and commands
module fss_top_tb;
   logic clk, rst_n, chan_enable_pin, bias_sense_pin, cmd_req, busy_now;
   logic rd_req, rd_valid, fault_shutdown, other_fault, input_detail_any;
   logic in_under_fault, temp_detail_any, cml_detail_any, mfr_detail_any;
   logic power_good_out, pg_enable, chan_output_on, alert_out_n, alert_oe;
   logic chan_latched, clear_pulse, chan_run_allow;
   logic [7:0]  cmd_code, rd_code, vd_ev, mask;
   logic [15:0] rd_data;
   int          n_errors, checks_done, i;

   fss_top u_dut (.*, .out_over_fault(vd_ev[7]), .out_over_warn(vd_ev[6]),
      .out_under_warn(vd_ev[5]), .out_under_fault(vd_ev[4]),
      .vout_max_req(vd_ev[3]), .ton_max_fault(vd_ev[2]));
   fss_host_model u_host (.*);

   // 10 MHz clock
   always #50 clk = ~clk;

   task close_out();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task rd(input logic [7:0] c, input logic [15:0] e);
      logic [15:0] d;
      logic        v;
      u_host.read_reg(c, d, v);
      chk(v, 1'h1);
      chk(d, e);
   endtask

   // one-cycle shutdown event
   task shut();
      @(negedge clk);
      fault_shutdown = 1'h1;
      @(negedge clk);
      fault_shutdown = 1'h0;
      chk(chan_latched, 1'h1);
      chk(chan_run_allow, 1'h0);
   endtask

   // watchdog
   initial begin
      #500000;
      n_errors++;
      close_out();
   end

   initial begin
      {clk, rst_n, chan_enable_pin, bias_sense_pin, busy_now} = 5'h00;
      {fault_shutdown, other_fault, input_detail_any, in_under_fault} = 4'h0;
      {temp_detail_any, cml_detail_any, mfr_detail_any} = 3'h0;
      {power_good_out, pg_enable, chan_output_on} = 3'h7;
      vd_ev = 8'h00;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(negedge clk);
      rst_n = 1'h1;
      repeat (4) @(negedge clk);
      rd(fss_pkg::CMD_SUM_FULL, 16'h0000);
      rd(8'h10, 16'h0000);
      // every output-voltage event in turn, bits accumulate
      mask = 8'h00;
      for (i = 7; i >= 2; i--) begin
         @(negedge clk);
         vd_ev[i] = 1'h1;
         @(negedge clk);
         vd_ev = 8'h00;
         mask[i] = 1'h1;
         chk(alert_out_n, 1'h0);
         rd(fss_pkg::CMD_VOUT_DETAIL, {8'h00, mask});
      end
      rd(fss_pkg::CMD_SUM_FULL, 16'h8021);
      rd(fss_pkg::CMD_SUM_LOW, 16'h0021);
      u_host.send_cmd(fss_pkg::CMD_CLEAR_FAULTS);
      chk(clear_pulse, 1'h1);
      chk(alert_out_n, 1'h1);
      rd(fss_pkg::CMD_VOUT_DETAIL, 16'h0000);
      // latched off, clear keeps it, each release path frees it
      chan_output_on = 1'h0;
      for (i = 0; i < 4; i++) begin
         shut();
         chk(alert_out_n, 1'h0);
         rd(fss_pkg::CMD_SUM_FULL, 16'h0040);
         u_host.send_cmd(fss_pkg::CMD_CLEAR_FAULTS);
         repeat (8) @(negedge clk);
         chk(chan_latched, 1'h1);
         chk(alert_out_n, 1'h1);
         case (i)
            0: u_host.send_cmd(fss_pkg::CMD_OPERATION);
            1: u_host.send_cmd(fss_pkg::CMD_ON_OFF_CFG);
            2: chan_enable_pin = 1'h1;
            default: bias_sense_pin = 1'h1;
         endcase
         repeat (6) @(negedge clk);
         chk(chan_latched, 1'h0);
         chk(chan_run_allow, 1'h1);
      end
      chan_output_on = 1'h1;
      rd(fss_pkg::CMD_SUM_FULL, 16'h0000);
      // command while busy, then an uncategorised fault
      busy_now = 1'h1;
      u_host.send_cmd(8'h55);
      busy_now = 1'h0;
      @(negedge clk);
      other_fault = 1'h1;
      @(negedge clk);
      other_fault = 1'h0;
      rd(fss_pkg::CMD_SUM_LOW, 16'h0081);
      u_host.send_cmd(fss_pkg::CMD_CLEAR_FAULTS);
      rd(fss_pkg::CMD_SUM_LOW, 16'h0000);
      // detail levels from elsewhere and power not good
      {input_detail_any, in_under_fault, temp_detail_any} = 3'h7;
      {cml_detail_any, mfr_detail_any, power_good_out} = 3'h6;
      rd(fss_pkg::CMD_SUM_FULL, 16'h380f);
      pg_enable = 1'h0;
      rd(fss_pkg::CMD_SUM_FULL, 16'h300f);
      close_out();
   end
endmodule
